/* include/bbc_params.svh */
/*
 holds opcode fields, widths and reset values for the branch and
 bit-clear executor. assumes inclusion by its bare name.
*/
`ifndef BBC_PARAMS_SVH
`define BBC_PARAMS_SVH
`define BBC_OP_BRANCH_CARRY 8'he2
`define BBC_OP_BRANCH_NEG 8'he6
`define BBC_OP_BIT_CLEAR 4'h9
`define BBC_INDEXED_MAX 8'h5f
`define BBC_PC_STEP 21'h000002
`define BBC_PC_RST 21'h000000
`define BBC_ACCESS_BANK 4'h0
`define BBC_ACCESS_SPLIT 8'h60
`define BBC_ACCESS_HIGH 4'hf
`endif

/* include/bbc_pkg.sv */
/*
 types shared by the executor and its quarter-phase sequencer.
 assumes bbc_params.svh is on the include path.
*/
package bbc_pkg;
    typedef enum logic [1:0] {BBC_Q1, BBC_Q2, BBC_Q3, BBC_Q4} bbc_phase_t;
    typedef enum logic [1:0] {BBC_ADDR_BANKED, BBC_ADDR_ACCESS,
        BBC_ADDR_INDEXED} bbc_addr_mode_t;
endpackage

/* src/bbc_quarter_seq.sv */
/*
 quarter-phase sequencer: q1..q4 per instruction cycle.
 assumes the core clock ticks once per quarter-phase.
*/
`timescale 1ns/1ps
module bbc_quarter_seq
(
    input wire logic clk_in,
    input wire logic srst_in,
    output bbc_pkg::bbc_phase_t phase_out,
    output logic cycle_end_out
);
    import bbc_pkg::*;
    typedef struct packed
    {
        bbc_phase_t phase_r;
    } bbc_seq_state_t;
    bbc_seq_state_t st_r;
    bbc_seq_state_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        case (st_r.phase_r)
            BBC_Q1: st_nxt.phase_r = BBC_Q2;
            BBC_Q2: st_nxt.phase_r = BBC_Q3;
            BBC_Q3: st_nxt.phase_r = BBC_Q4;
            BBC_Q4: st_nxt.phase_r = BBC_Q1;
            default: st_nxt.phase_r = BBC_Q1;
        endcase
    end
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            st_r <= '{phase_r: BBC_Q1};
        else
            st_r <= st_nxt;
    end
    assign phase_out = st_r.phase_r;
    assign cycle_end_out = (st_r.phase_r == BBC_Q4);
endmodule

/* src/bbc_exec.sv */
/*
 decode and execute of branch_on_carry, branch_on_negative and
 bit_clear_file. assumes instr_in and the flags stay stable over a whole
 instruction cycle, and that the data-memory read answers in the same
 cycle as the address.
*/
`timescale 1ns/1ps
`include "bbc_params.svh"
module bbc_exec
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [15:0] instr_in,
    input wire logic instr_valid_in,
    input wire logic carry_in,
    input wire logic negative_in,
    input wire logic ext_set_in,
    input wire logic [3:0] bank_select_register_in,
    input wire logic [20:0] fsr2_base_in,
    input wire logic [7:0] mem_rdata_in,
    output logic [20:0] pc_out,
    output logic [11:0] mem_addr_out,
    output logic [20:0] mem_xaddr_out,
    output logic mem_indexed_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [7:0] mem_wdata_out,
    output logic flush_out,
    output bbc_pkg::bbc_phase_t phase_out,
    output logic status_we_out
);
    import bbc_pkg::*;
    typedef struct packed
    {
        logic [20:0] pc_r;
        logic [20:0] target_r;
        logic take_r;
        logic nop_cycle_r;
        logic [11:0] addr_r;
        logic [20:0] xaddr_r;
        logic indexed_r;
        logic [2:0] bit_r;
        logic rd_r;
        logic wr_r;
        logic [7:0] wdata_r;
        logic flag_we_r;
        bbc_phase_t phase_r;
    } bbc_state_t;
    bbc_state_t st_r;
    bbc_state_t st_nxt;
    bbc_phase_t seq_phase;
    logic seq_end;
    logic is_bc;
    logic is_bn;
    logic is_bcf;
    logic [20:0] offs;
    logic [7:0] fa;
    logic [7:0] clr_mask;
    bbc_addr_mode_t amode;

    bbc_quarter_seq u_seq
    (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .phase_out(seq_phase),
        .cycle_end_out(seq_end)
    );

    always_comb
    begin
        is_bc = (instr_in[15:8] == `BBC_OP_BRANCH_CARRY);
        is_bn = (instr_in[15:8] == `BBC_OP_BRANCH_NEG);
        is_bcf = (instr_in[15:12] == `BBC_OP_BIT_CLEAR);
        // sign-extend and double the offset
        offs = {{12{instr_in[7]}}, instr_in[7:0], 1'b0};
        fa = instr_in[7:0];
        // mask from the latched bit select, not the live word
        clr_mask = ~(8'h01 << st_r.bit_r);
        if (instr_in[8])
        begin
            amode = BBC_ADDR_BANKED;
        end
        else if (ext_set_in && fa <= `BBC_INDEXED_MAX)
        begin
            amode = BBC_ADDR_INDEXED;
        end
        else
        begin
            amode = BBC_ADDR_ACCESS;
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.phase_r = seq_phase;
        st_nxt.rd_r = 1'b0;
        st_nxt.wr_r = 1'b0;
        // registered zero drives the output from a flip-flop
        st_nxt.flag_we_r = 1'b0;
        if (st_r.nop_cycle_r)
        begin
            // fetch of the target; every quarter idle
            if (seq_end)
            begin
                st_nxt.nop_cycle_r = 1'b0;
            end
        end
        else if (instr_valid_in)
        begin
            case (seq_phase)
                BBC_Q1:
                begin
                    st_nxt.take_r = (is_bc && carry_in)
                        || (is_bn && negative_in);
                    st_nxt.bit_r = instr_in[11:9];
                end
                BBC_Q2:
                begin
                    if (is_bcf)
                    begin
                        st_nxt.indexed_r = (amode == BBC_ADDR_INDEXED);
                        st_nxt.xaddr_r = fsr2_base_in
                            + {13'h0000, fa};
                        case (amode)
                            BBC_ADDR_BANKED:
                            begin
                                st_nxt.addr_r =
                                    {bank_select_register_in, fa};
                            end
                            default:
                            begin
                                // indexed keeps an access address as spare
                                if (fa < `BBC_ACCESS_SPLIT)
                                begin
                                    st_nxt.addr_r =
                                        {`BBC_ACCESS_BANK, fa};
                                end
                                else
                                begin
                                    st_nxt.addr_r =
                                        {`BBC_ACCESS_HIGH, fa};
                                end
                            end
                        endcase
                        st_nxt.rd_r = 1'b1;
                    end
                end
                BBC_Q3:
                begin
                    st_nxt.target_r = st_r.pc_r + `BBC_PC_STEP + offs;
                    if (is_bcf)
                    begin
                        st_nxt.wdata_r = mem_rdata_in & clr_mask;
                    end
                end
                BBC_Q4:
                begin
                    if (is_bcf)
                    begin
                        st_nxt.wr_r = 1'b1;
                    end
                    if (st_r.take_r)
                    begin
                        st_nxt.pc_r = st_r.target_r;
                        st_nxt.nop_cycle_r = 1'b1;
                    end
                    else
                    begin
                        st_nxt.pc_r = st_r.pc_r + `BBC_PC_STEP;
                    end
                end
                default: st_nxt.phase_r = BBC_Q1;
            endcase
        end
        else if (seq_end)
        begin
            // no valid word: the slot still advances the pc by one step of 2
            st_nxt.pc_r = st_r.pc_r + `BBC_PC_STEP;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            st_r <= '0;
            st_r.pc_r <= `BBC_PC_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pc_out = st_r.pc_r;
    assign mem_addr_out = st_r.addr_r;
    assign mem_xaddr_out = st_r.xaddr_r;
    assign mem_indexed_out = st_r.indexed_r;
    assign mem_rd_out = st_r.rd_r;
    assign mem_wr_out = st_r.wr_r;
    assign mem_wdata_out = st_r.wdata_r;
    assign flush_out = st_r.nop_cycle_r;
    assign phase_out = st_r.phase_r;
    // these instructions never touch status flags
    assign status_we_out = st_r.flag_we_r;
endmodule

/* sim/bbc_exec_chk.sv */
/* port checker for bbc_exec.
 assumes binding onto every bbc_exec instance. */
`timescale 1ns/1ps
module bbc_exec_chk
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [15:0] instr_in,
    input wire logic ext_set_in,
    input wire logic [3:0] bank_select_register_in,
    input wire logic [20:0] pc_out,
    input wire logic [11:0] mem_addr_out,
    input wire logic mem_indexed_out,
    input wire logic mem_rd_out,
    input wire logic mem_wr_out,
    input wire logic [7:0] mem_wdata_out,
    input wire logic flush_out,
    input wire logic status_we_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (srst_in);
property p_no_flags; !status_we_out; endproperty
a_no_flags: assert property (p_no_flags)
    else $error("flag write");
property p_rd_wr; mem_wr_out |-> $past(mem_rd_out, 2); endproperty
a_rd_wr: assert property (p_rd_wr)
    else $error("write without read");
property p_flush_len; $rose(flush_out) |-> flush_out [*4] ##1 !flush_out;
endproperty
a_flush_len: assert property (p_flush_len)
    else $error("flush length");
property p_flush_pc; flush_out && $past(flush_out) |-> $stable(pc_out);
endproperty
a_flush_pc: assert property (p_flush_pc)
    else $error("pc moved in flush");
property p_clr_bit; mem_wr_out |-> !mem_wdata_out[instr_in[11:9]];
endproperty
a_clr_bit: assert property (p_clr_bit)
    else $error("bit not cleared");
property p_index; mem_wr_out |-> mem_indexed_out ==
    (ext_set_in && !instr_in[8] && instr_in[7:0] <= 8'h5f); endproperty
a_index: assert property (p_index)
    else $error("indexed mode wrong");
property p_bank; mem_wr_out && instr_in[8] |->
    mem_addr_out == {bank_select_register_in, instr_in[7:0]}; endproperty
a_bank: assert property (p_bank)
    else $error("banked address wrong");
property p_target; $rose(flush_out) |-> pc_out == $past(pc_out) + 21'h2
    + {{12{instr_in[7]}}, instr_in[7:0], 1'b0}; endproperty
a_target: assert property (p_target)
    else $error("branch target wrong");
endmodule
bind bbc_exec bbc_exec_chk i_bbc_exec_chk(.*);

/* sim/tb.sv */
/* bench for bbc_exec: branches and bit clear.
 assumes bbc_pkg and the checker are compiled first. */
`timescale 1ns/1ps
module tb;
import bbc_pkg::*;
logic clk_in = 0, srst_in = 1, instr_valid_in = 1;
logic carry_in = 0, negative_in = 0, ext_set_in = 0;
logic [15:0] instr_in = 16'h0000;
logic [3:0] bank_select_register_in = 4'h0;
logic [20:0] fsr2_base_in = 21'h001000, pc_out, mem_xaddr_out;
logic [7:0] mem_rdata_in = 8'h00, mem_wdata_out;
logic [11:0] mem_addr_out;
logic mem_indexed_out, mem_rd_out, mem_wr_out, flush_out, status_we_out;
bbc_phase_t phase_out;
int num_errors = 0, cmp_count = 0;
always #12.5 clk_in = ~clk_in;
bbc_exec i_bbc_exec(.*);
task chk(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
        num_errors++;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
endtask
// reset per case so pc starts at zero
task go(input logic [15:0] i, input logic c, n, e,
    input logic [3:0] k, input logic [7:0] r);
    @(posedge clk_in);
    srst_in <= 1'b1;
    instr_in <= i;
    carry_in <= c;
    negative_in <= n;
    ext_set_in <= e;
    bank_select_register_in <= k;
    mem_rdata_in <= r;
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
endtask
task br(input logic [7:0] op, input logic c, n, input logic [7:0] d);
    logic tk;
    logic [20:0] xp;
    tk = (op == 8'he2) ? c : n;
    xp = tk ? 21'h2 + {{12{d[7]}}, d, 1'b0} : 21'h2;
    go({op, d}, c, n, 1'b0, 4'h0, 8'h00);
    repeat (2) @(posedge clk_in);
    #1;
    chk(pc_out, xp);
    chk(flush_out, tk);
    chk(status_we_out, 1'b0);
    repeat (4) @(posedge clk_in);
    #1;
    chk(flush_out, 1'b0);
    chk(pc_out, tk ? xp : 21'h4);
endtask
task t_other;
    go(16'h1234, 1'b1, 1'b1, 1'b0, 4'h0, 8'h00);
    repeat (2) @(posedge clk_in);
    #1;
    chk(pc_out, 21'h2);
    chk(flush_out, 1'b0);
    chk(mem_wr_out, 1'b0);
    $display("t_other done");
endtask
task bc(input logic [2:0] b, input logic a, e, input logic [3:0] k,
    input logic [7:0] f, r);
    logic ix;
    ix = e && !a && f <= 8'h5f;
    go({4'h9, b, a, f}, 1'b1, 1'b1, e, k, r);
    chk(mem_rd_out, 1'b1);
    chk(phase_out, 21'h1);
    repeat (2) @(posedge clk_in);
    #1;
    chk(mem_wr_out, 1'b1);
    chk(mem_wdata_out, r & ~(8'h01 << b));
    chk(mem_indexed_out, ix);
    chk(status_we_out, 1'b0);
    if (ix) chk(mem_xaddr_out, fsr2_base_in + f);
    else chk(mem_addr_out,
        a ? {k, f} : {(f < 8'h60 ? 4'h0 : 4'hf), f});
endtask
task t_carry;
    br(8'he2, 1'b1, 1'b0, 8'h05);
    br(8'he2, 1'b0, 1'b1, 8'h05);
    br(8'he2, 1'b1, 1'b0, 8'h80);
    $display("t_carry done");
endtask
task t_neg;
    br(8'he6, 1'b0, 1'b1, 8'h7f);
    br(8'he6, 1'b1, 1'b0, 8'h7f);
    $display("t_neg done");
endtask
task t_bcf;
    bc(3'h7, 1'b0, 1'b0, 4'h0, 8'h10, 8'hc7);
    bc(3'h0, 1'b1, 1'b1, 4'h5, 8'h34, 8'hff);
    bc(3'h3, 1'b0, 1'b1, 4'h0, 8'h5f, 8'hff);
    bc(3'h3, 1'b0, 1'b1, 4'h0, 8'h60, 8'h0f);
    $display("t_bcf done");
endtask
task test_done;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
initial
begin
    t_carry;
    t_neg;
    t_bcf;
    t_other;
    test_done;
end
initial
begin
    #20000;
    num_errors++;
    test_done;
end
endmodule
